// file: logic/private_vlan_forward_mask.v
// Private VLAN forwarding mask, tag decision and private VLAN table
`timescale 1ns/1ps
`include "pvlan_defines.vh"
module private_vlan_forward_mask (
	input wire ref_clk_in,
	input wire arst_n_in,
	// Per-port configuration
	input wire [`NPORTS-1:0] cfg_isolate_in,
	input wire [`NPORTS-1:0] cfg_vlan_aware_in,
	input wire [`NPORTS-1:0] cfg_ingress_filter_in,
	input wire [`NPORTS-1:0] cfg_tagged_only_in,
	input wire cfg_write_in,
	input wire cfg_commit_in,
	// Private VLAN table edit port
	input wire pv_write_in,
	input wire [`PIDX_W-1:0] pv_id_in,
	input wire [`NPORTS-1:0] pv_mask_in,
	input wire pv_delete_in,
	// Default VLAN edit port
	input wire port_default_vlan_id_write_in,
	input wire [`PIDX_W-1:0] port_default_vlan_id_port_in,
	input wire [`VID_W-1:0] port_default_vlan_id_value_in,
	// Frame lookup request
	input wire frm_valid_in,
	input wire [`PIDX_W-1:0] frm_port_in,
	input wire frm_tagged_in,
	input wire [`VID_W-1:0] frm_tag_vid_in,
	// Answer from the VLAN lookup for the classified id
	input wire [`NPORTS-1:0] vlan_member_in,
	input wire [`NPORTS-1:0] vlan_untag_in,
	input wire [`NPORTS-1:0] src_vlan_any_in,
	output reg [`VID_W-1:0] lookup_vid_out,
	output reg pv_reject_out,
	output reg [`NPORTS-1:0] isolate_out,
	output reg fwd_valid_out,
	output reg fwd_drop_out,
	output reg [`NPORTS-1:0] fwd_mask_out,
	output reg [`NPORTS-1:0] fwd_strip_out,
	output reg [`VID_W-1:0] fwd_vid_out
);

// --------------------------------------------------
// Configuration state
// --------------------------------------------------
reg [`NPORTS-1:0] pv_tab_q [1:`NPORTS];
reg [`NPORTS-1:0] pv_shadow_q [1:`NPORTS];
reg [`VID_W-1:0] port_default_vlan_id_q [0:`NPORTS-1];
reg [`NPORTS-1:0] aware_q;
reg [`NPORTS-1:0] filt_q;
reg [`NPORTS-1:0] tonly_q;

// --------------------------------------------------
// Decode of the current request
// --------------------------------------------------
wire pv_id_ok;
wire pv_id_nonzero;
wire pv_id_in_range;
wire [`NPORTS-1:0] src_bit;
wire [`NPORTS-1:0] pv_union;
wire [`NPORTS-1:0] promisc_set;
wire [`NPORTS-1:0] vlan_dest;
wire [`NPORTS-1:0] pv_dest;
wire src_isolated;
wire src_aware;
wire src_filtered;
wire src_tagged_only;
wire src_in_pvlan;
wire src_in_vlan;
wire src_in_member;
reg [`NPORTS-1:0] pv_src_mask;
reg [`NPORTS-1:0] mask_d;
reg [`NPORTS-1:0] strip_d;
reg drop_d;
reg [`VID_W-1:0] vid_d;
integer k;

// Ids run 1..NPORTS, while port numbers run 0..NPORTS-1; id 0 has no row
assign pv_id_nonzero = (pv_id_in != 5'h00);
assign pv_id_in_range = (pv_id_in <= `PV_ID_MAX);
assign pv_id_ok = pv_id_nonzero && pv_id_in_range;

assign src_bit = {{(`NPORTS-1){1'b0}}, 1'b1} << frm_port_in;
assign promisc_set = ~isolate_out;

assign src_isolated = |(isolate_out & src_bit);
assign src_aware = |(aware_q & src_bit);
assign src_filtered = |(filt_q & src_bit);
assign src_tagged_only = |(tonly_q & src_bit);
assign src_in_pvlan = |(pv_union & src_bit);
assign src_in_vlan = |src_vlan_any_in;
assign src_in_member = |(vlan_member_in & src_bit);

// --------------------------------------------------
// Private VLAN table and default VLAN ids
// --------------------------------------------------
genvar g;
generate
	for (g = 1; g <= `NPORTS; g = g + 1) begin : g_pv
		// Shadow edits apply to the live table only at commit
		always @(posedge ref_clk_in or negedge arst_n_in) begin
			if (!arst_n_in) begin
				pv_tab_q[g] <= (g == 1) ? {`NPORTS{1'b1}} :
					{`NPORTS{1'b0}};
				pv_shadow_q[g] <= (g == 1) ? {`NPORTS{1'b1}} :
					{`NPORTS{1'b0}};
			end else begin
				if (pv_write_in && pv_id_ok && pv_id_in == g) begin
					// Deleted entry is empty; a written entry takes pv_mask_in
					pv_shadow_q[g] <= pv_delete_in ?
						{`NPORTS{1'b0}} : pv_mask_in;
				end
				if (cfg_commit_in) begin
					pv_tab_q[g] <= pv_shadow_q[g];
				end
			end
		end
	end
	for (g = 0; g < `NPORTS; g = g + 1) begin : g_port
		// A zero id is no VLAN; it is ignored, the old id stays
		always @(posedge ref_clk_in or negedge arst_n_in) begin
			if (!arst_n_in) begin
				port_default_vlan_id_q[g] <= `DEFAULT_VID;
			end else if (port_default_vlan_id_write_in && port_default_vlan_id_port_in == g &&
				port_default_vlan_id_value_in != 12'h000) begin
				port_default_vlan_id_q[g] <= port_default_vlan_id_value_in;
			end
		end
	end
endgenerate

// --------------------------------------------------
// Private VLAN membership of each port
// --------------------------------------------------
generate
	for (g = 0; g < `NPORTS; g = g + 1) begin : g_union
		wire [`NPORTS-1:0] col;
		genvar h;
		for (h = 1; h <= `NPORTS; h = h + 1) begin : g_col
			assign col[h-1] = pv_tab_q[h][g];
		end
		assign pv_union[g] = |col;
	end
endgenerate

// Ports sharing at least one private VLAN with the source
always @* begin
	pv_src_mask = {`NPORTS{1'b0}};
	for (k = 1; k <= `NPORTS; k = k + 1) begin
		if (|(pv_tab_q[k] & src_bit)) begin
			pv_src_mask = pv_src_mask | pv_tab_q[k];
		end
	end
end

// --------------------------------------------------
// Destination candidates per port
// --------------------------------------------------
generate
	for (g = 0; g < `NPORTS; g = g + 1) begin : g_dest
		// Promiscuous sources see the VLAN mask alone
		assign vlan_dest[g] = vlan_member_in[g] &&
			!src_bit[g];
		// Isolated sources reach only promiscuous group members
		assign pv_dest[g] = vlan_dest[g] && pv_src_mask[g] &&
			promisc_set[g];
	end
endgenerate

// --------------------------------------------------
// Classification, registered into lookup_vid_out for the VLAN lookup
// --------------------------------------------------
always @* begin
	vid_d = port_default_vlan_id_q[frm_port_in];
	if (src_aware && frm_tagged_in) begin
		vid_d = frm_tag_vid_in;
	end
end

// --------------------------------------------------
// Forward or drop decision
// --------------------------------------------------
always @* begin
	drop_d = 1'b0;
	if (src_isolated) begin
		mask_d = pv_dest;
	end else begin
		mask_d = vlan_dest;
	end
	if (!src_in_vlan || !src_in_pvlan) begin
		drop_d = 1'b1;
	end
	if (src_filtered && !src_in_member) begin
		drop_d = 1'b1;
	end
	if (src_tagged_only && !frm_tagged_in) begin
		drop_d = 1'b1;
	end
	if (mask_d == {`NPORTS{1'b0}}) begin
		drop_d = 1'b1;
	end
	// A dropped frame must not leak a partial mask downstream
	if (drop_d) begin
		mask_d = {`NPORTS{1'b0}};
	end
end

// Strip on untagged members, keep tag elsewhere
always @* begin
	strip_d = mask_d & vlan_untag_in;
end

// --------------------------------------------------
// Port settings
// --------------------------------------------------
always @(posedge ref_clk_in or negedge arst_n_in) begin
	if (!arst_n_in) begin
		isolate_out <= {`NPORTS{1'b0}};
		aware_q <= {`NPORTS{1'b0}};
		filt_q <= {`NPORTS{1'b0}};
		tonly_q <= {`NPORTS{1'b0}};
	end else if (cfg_write_in) begin
		isolate_out <= cfg_isolate_in;
		aware_q <= cfg_vlan_aware_in;
		filt_q <= cfg_ingress_filter_in;
		tonly_q <= cfg_tagged_only_in;
	end
end

// --------------------------------------------------
// Table edit status
// --------------------------------------------------
always @(posedge ref_clk_in or negedge arst_n_in) begin
	if (!arst_n_in) begin
		pv_reject_out <= 1'b0;
	end else begin
		pv_reject_out <= pv_write_in && !pv_id_ok;
	end
end

// --------------------------------------------------
// Classified id seen by the lookup, one cycle late
// --------------------------------------------------
always @(posedge ref_clk_in or negedge arst_n_in) begin
	if (!arst_n_in) begin
		lookup_vid_out <= `DEFAULT_VID;
	end else begin
		lookup_vid_out <= vid_d;
	end
end

// --------------------------------------------------
// Forwarding result
// --------------------------------------------------
always @(posedge ref_clk_in or negedge arst_n_in) begin
	if (!arst_n_in) begin
		fwd_valid_out <= 1'b0;
		fwd_drop_out <= 1'b0;
		fwd_mask_out <= {`NPORTS{1'b0}};
		fwd_strip_out <= {`NPORTS{1'b0}};
	end else begin
		fwd_valid_out <= frm_valid_in;
		fwd_drop_out <= frm_valid_in && drop_d;
		if (frm_valid_in) begin
			fwd_mask_out <= mask_d;
			fwd_strip_out <= strip_d;
		end else begin
			fwd_mask_out <= {`NPORTS{1'b0}};
			fwd_strip_out <= {`NPORTS{1'b0}};
		end
	end
end

// Id held until the next frame so egress can read it late
always @(posedge ref_clk_in or negedge arst_n_in) begin
	if (!arst_n_in) begin
		fwd_vid_out <= `DEFAULT_VID;
	end else if (frm_valid_in) begin
		fwd_vid_out <= vid_d;
	end
end

endmodule // private_vlan_forward_mask

// file: logic/pvlan_defines.vh
// Constants for the private VLAN forwarding mask block
`ifndef PVLAN_DEFINES_VH
`define PVLAN_DEFINES_VH
`define NPORTS 20
`define PIDX_W 5
`define PV_ID_MAX 5'h14
`define VID_W 12
`define DEFAULT_VID 12'h001
`define DEFAULT_PVLAN 5'h01
`endif

// file: test/pvlan_checker.sv
// Port assertions for the forwarding mask block
`timescale 1ns/1ps
module pvlan_checker(input wire ref_clk_in,arst_n_in,frm_valid_in,
	pv_write_in,fwd_valid_out,fwd_drop_out,pv_reject_out,
	input wire [4:0] frm_port_in,pv_id_in,
	input wire [19:0] src_vlan_any_in,vlan_member_in,vlan_untag_in,
	isolate_out,fwd_mask_out,fwd_strip_out);
default clocking @(posedge ref_clk_in); endclocking
default disable iff (!arst_n_in);
a_answer_next: assert property(frm_valid_in|=>fwd_valid_out)
	else $error("no answer");
a_src_out: assert property(frm_valid_in|=>
	!fwd_mask_out[$past(frm_port_in)]) else $error("source kept");
a_drop_empty: assert property(fwd_valid_out|->
	fwd_drop_out==(fwd_mask_out==0)) else $error("drop flag");
a_vlan_only: assert property(frm_valid_in|=>
	!(fwd_mask_out&~$past(vlan_member_in))) else $error("non member");
a_strip_set: assert property(frm_valid_in|=>
	fwd_strip_out==(fwd_mask_out&$past(vlan_untag_in))) else $error("strip");
a_no_vlan: assert property(frm_valid_in&&!src_vlan_any_in|=>
	fwd_drop_out) else $error("no drop");
a_id_range: assert property(pv_write_in|=>pv_reject_out==
	($past(pv_id_in)==0||$past(pv_id_in)>5'h14)) else $error("range");
a_iso_pair: assert property(frm_valid_in&&isolate_out[frm_port_in]|=>
	!(fwd_mask_out&$past(isolate_out))) else $error("isolated reach");
a_promisc_mask: assert property(frm_valid_in&&
	!isolate_out[frm_port_in]|=>fwd_drop_out||fwd_mask_out==
	($past(vlan_member_in)&~(20'h1<<$past(frm_port_in))))
	else $error("promiscuous mask");
c_iso: cover property(frm_valid_in&&isolate_out[frm_port_in]);
c_drop: cover property(fwd_valid_out&&fwd_drop_out);
c_rej: cover property(pv_reject_out);
endmodule // pvlan_checker
bind private_vlan_forward_mask pvlan_checker pvlan_checker_inst(.*);

// file: test/eth_station.sv
// Station model: one frame request per go pulse
`timescale 1ns/1ps
module eth_station(input wire ref_clk_in,go_in,tag_in,
	input wire [4:0] port_in,input wire [11:0] vid_in,
	output reg valid_out=0,tag_out=0,output reg [4:0] port_out=0,
	output reg [11:0] vid_out=0);
// Idle lines toggle so a stale frame is never mistaken for a live one
always @(posedge ref_clk_in) begin
	valid_out<=go_in;
	{tag_out,port_out,vid_out}<=go_in?{tag_in,port_in,vid_in}:
		~{tag_out,port_out,vid_out};
end
endmodule // eth_station

// file: test/private_vlan_forward_mask_tb.sv
// Self-checking bench for the forwarding mask block
`timescale 1ns/1ps
module private_vlan_forward_mask_tb;
reg ref_clk_in=0,arst_n_in=0,cw=0,cc=0,pw=0,pd=0,qw=0,go=0,tg=0;
reg [19:0] iso=0,aw=0,flt=0,tgo=0,pm=0,vm=0,un=0,an=0,sh[1:20],pv[1:20];
reg [4:0] pid=0,qp=0,sp=0;
reg [11:0] qv=0,tv=0,port_default_vlan_id[0:19];
reg [31:0] rs=92298;
integer n_mismatch=0,num_checks=0,k;
wire fv,fd,rj,v,t;
wire [19:0] io,fm,fs;
wire [11:0] fid,id,lv;
wire [4:0] p;
eth_station eth_station_inst(.ref_clk_in(ref_clk_in),.go_in(go),
	.tag_in(tg),.port_in(sp),.vid_in(tv),.valid_out(v),.tag_out(t),
	.port_out(p),.vid_out(id));
private_vlan_forward_mask private_vlan_forward_mask_inst(
	.ref_clk_in(ref_clk_in),.arst_n_in(arst_n_in),.cfg_isolate_in(iso),
	.cfg_vlan_aware_in(aw),.cfg_ingress_filter_in(flt),
	.cfg_tagged_only_in(tgo),.cfg_write_in(cw),.cfg_commit_in(cc),
	.pv_write_in(pw),.pv_id_in(pid),.pv_mask_in(pm),.pv_delete_in(pd),
	.port_default_vlan_id_write_in(qw),.port_default_vlan_id_port_in(qp),.port_default_vlan_id_value_in(qv),
	.frm_valid_in(v),.frm_port_in(p),.frm_tagged_in(t),.frm_tag_vid_in(id),
	.vlan_member_in(vm),.vlan_untag_in(un),.src_vlan_any_in(an),
	.lookup_vid_out(lv),.pv_reject_out(rj),.isolate_out(io),
	.fwd_valid_out(fv),.fwd_drop_out(fd),.fwd_mask_out(fm),
	.fwd_strip_out(fs),.fwd_vid_out(fid));
initial forever #20 ref_clk_in=~ref_clk_in;
function [31:0] xs();
	begin rs=rs^(rs<<13); rs=rs^(rs>>17); rs=rs^(rs<<5); xs=rs; end
endfunction
task tick; @(posedge ref_clk_in); endtask
task cmp(input [19:0] g,e);
	begin num_checks=num_checks+1; if(g!==e) begin n_mismatch=n_mismatch+1;
	$display("MISMATCH %0t got %h exp %h",$time,g,e); end end
endtask
task frm(input [4:0] s);
	reg [19:0] u,e; reg d; reg [31:0] r;
	begin
		u=0; r=xs();
		for(k=1;k<21;k=k+1) if(pv[k][s]) u=u|pv[k];
		tick; vm<=xs(); un<=xs(); an<=r[3:0]?r:0; tg<=r[4]; tv<=r[27:16]|1;
		sp<=s; go<=1; tick; go<=0; tick; #1;
		e=vm&~(20'h1<<s)&(iso[s]?u&~iso:~20'h0);
		d=!an||!u||flt[s]&&!vm[s]||tgo[s]&&!tg||!e;
		cmp(fm,d?0:e);
		cmp(fd,d);
		cmp(fs,d?0:e&un);
		if(!d) cmp(fid,aw[s]&&tg?tv:port_default_vlan_id[s]);
		cmp(lv,aw[s]&&tg?tv:port_default_vlan_id[s]);
	end
endtask
task pvw(input [4:0] i,input [19:0] m,input x);
	begin tick; pw<=1; pid<=i; pm<=m; pd<=x; tick; pw<=0; #1;
	cmp(rj,i<1||i>20);
	if(i>0&&i<21) sh[i]=x?0:m; end
endtask
task complete_run;
	begin
		$display("checks %0d mismatches %0d",num_checks,n_mismatch);
		if(n_mismatch==0&&num_checks>0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	end
endtask
initial begin #100000; n_mismatch=n_mismatch+1; complete_run; end
initial begin
	for(k=0;k<20;k=k+1) port_default_vlan_id[k]=1;
	for(k=1;k<21;k=k+1) begin pv[k]=k<2?~20'h0:0; sh[k]=pv[k]; end
	repeat(6) tick;
	arst_n_in<=1; #1 cmp(io,0);
	repeat(8) frm(xs()%20);
	tick; qw<=1; qp<=5'h03; qv<=12'h005; tick; qw<=0; port_default_vlan_id[3]=5;
	frm(5'h03);
	$display("defaults done");
	tick; iso<=xs(); aw<=xs(); flt<=xs()&xs(); tgo<=xs()&xs(); cw<=1;
	tick; cw<=0; #1 cmp(io,iso);
	repeat(30) frm(xs()%20);
	$display("isolation done");
	pvw(0,1,0); pvw(21,1,0); pvw(2,xs(),0); pvw(1,0,1);
	frm(xs()%20);
	tick; cc<=1; tick; cc<=0; for(k=1;k<21;k=k+1) pv[k]=sh[k];
	repeat(20) frm(xs()%20);
	$display("table done");
	complete_run;
end
endmodule // private_vlan_forward_mask_tb
